// ===== logic/hpc_device.sv
// Device end of the host port: control register shared by host and CPU.
// Assumes the CPU reaches it over APB and memory/FIFO logic sits on the user side.
`timescale 1ns/1ps
`default_nettype none
module hpc_device #(
   parameter int FIFO_RST_CYCLES = hpc_pkg::FIFO_RST_CYCLES_DEF
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        boot_from_port,
   hpc_link_if.device       link,
   output logic             cpu_irq,
   output logic             fifo_flush,
   output logic             fetch_req,
   output logic             mem_wr,
   output logic      [31:0] mem_addr,
   output logic      [31:0] mem_wdata,
   input  wire logic [31:0] mem_rdata
);
   import hpc_pkg::*;

   typedef struct packed {
      logic                 init;
      logic                 dual;
      logic                 halfword_order;
      logic                 srst;
      logic                 rst_req;
      logic                 rst_busy;
      logic [RST_CNT_W-1:0] rst_cnt;
      logic                 cpu_to_host_irq;
      logic                 host_to_cpu_irq;
      logic [31:0]          rd_addr;
      logic [31:0]          wr_addr;
      logic [31:0]          hold;
      logic                 half_pend;
      logic                 ack;
      logic [15:0]          rdata;
      logic                 fetch;
      logic                 mem_wr;
      logic [31:0]          mem_addr;
      logic [31:0]          mem_wdata;
      logic                 pready;
      logic [31:0]          prdata;
      logic                 pslverr;
   } hpc_dev_s;

   hpc_dev_s s;
   hpc_dev_s next_s;

   localparam logic [RST_CNT_W-1:0] RST_LAST = RST_CNT_W'(FIFO_RST_CYCLES - 1);

   logic        accept;
   logic        int_ready;
   logic        cpu_wr;
   logic        host_wr_done;
   logic [31:0] host_word;
   logic [31:0] ctl_low;
   logic [31:0] rd_word;
   logic        host_cpu_to_host_irq_clr;
   logic        host_dsp_set;
   logic        cpu_cpu_to_host_irq_set;
   logic        cpu_dsp_clr;

   always_comb begin
      next_s = s;
      next_s.ack    = 1'b0;
      next_s.fetch  = 1'b0;
      next_s.mem_wr = 1'b0;
      host_cpu_to_host_irq_clr = 1'b0;
      host_dsp_set  = 1'b0;
      ctl_low       = 32'h0000_0000;
      rd_word       = 32'h0000_0000;
      next_s.init   = 1'b1;
      if (!s.init) begin
         next_s.srst = ~boot_from_port;
      end

      int_ready = s.init & ~s.rst_busy & ~s.srst & ~s.rst_req;
      // hold off new cycles; let open cycle finish
      accept = link.req & ~s.ack & s.init & ~s.rst_busy & (s.half_pend | ~(s.srst | s.rst_req));

      // Host view of control: mirror, read zero
      ctl_low[BIT_DUAL]   = s.dual;
      ctl_low[BIT_HWOSTA] = s.halfword_order;
      ctl_low[BIT_RDY]    = int_ready;
      ctl_low[BIT_CPU_TO_HOST_IRQ]   = s.cpu_to_host_irq;
      ctl_low[BIT_DSPI]   = s.host_to_cpu_irq;
      ctl_low[BIT_HALFWORD_ORDER]   = s.halfword_order;

      unique case (link.cntl)
         CNTL_CTRL:  rd_word = {ctl_low[15:0], ctl_low[15:0]};
         // single mode reads the read address
         CNTL_WADDR: rd_word = s.dual ? s.wr_addr : s.rd_addr;
         CNTL_RADDR: rd_word = s.rd_addr;
         CNTL_DATA:  rd_word = mem_rdata;
      endcase

      host_word    = hpc_join(s.hold[15:0], link.wdata, s.halfword_order);
      host_wr_done = accept & ~link.rw & s.half_pend;

      if (accept) begin
         next_s.ack       = 1'b1;
         next_s.half_pend = ~s.half_pend;
         if (link.rw) begin
            if (!s.half_pend) begin
               next_s.hold  = rd_word;
               next_s.rdata = hpc_half(rd_word, s.halfword_order, 1'b0);
            end else begin
               next_s.rdata = hpc_half(s.hold, s.halfword_order, 1'b1);
               if (link.cntl == CNTL_DATA) begin
                  next_s.rd_addr = s.rd_addr + ADDR_STEP;
                  if (!s.dual) begin
                     next_s.wr_addr = s.wr_addr + ADDR_STEP;
                  end
               end
            end
         end else if (!s.half_pend) begin
            next_s.hold = {16'h0000, link.wdata};
         end
      end

      if (host_wr_done) begin
         unique case (link.cntl)
            CNTL_CTRL: begin
               // reserved and soft reset bits not stored from host
               next_s.dual   = host_word[BIT_DUAL];
               next_s.halfword_order   = host_word[BIT_HALFWORD_ORDER];
               next_s.fetch  = host_word[BIT_FETCH];
               host_cpu_to_host_irq_clr = host_word[BIT_CPU_TO_HOST_IRQ];
               host_dsp_set  = host_word[BIT_DSPI];
            end
            CNTL_WADDR, CNTL_RADDR: begin
               if (!s.dual || link.cntl == CNTL_WADDR) begin
                  next_s.wr_addr = host_word;
               end
               if (!s.dual || link.cntl == CNTL_RADDR) begin
                  next_s.rd_addr = host_word;
               end
            end
            CNTL_DATA: begin
               next_s.mem_wr    = 1'b1;
               next_s.mem_wdata = host_word;
               next_s.wr_addr   = s.wr_addr + ADDR_STEP;
               if (!s.dual) begin
                  next_s.rd_addr = s.rd_addr + ADDR_STEP;
               end
            end
         endcase
      end
      next_s.mem_addr = next_s.mem_wr ? s.wr_addr : next_s.rd_addr;

      // CPU access over APB; pready answers in the first access cycle
      next_s.pready  = psel & ~penable & ~s.pready;
      cpu_wr         = psel & penable & pwrite & s.pready;
      next_s.prdata  = 32'h0000_0000;
      next_s.pslverr = 1'b0;
      if (psel && !penable) begin
         if (paddr == DEV_CTRL_OFS) begin
            // soft reset reads zero until FIFO reset is over; ready reads zero
            next_s.prdata[BIT_DUAL]   = s.dual;
            next_s.prdata[BIT_HWOSTA] = s.halfword_order;
            next_s.prdata[BIT_SRST]   = s.srst & ~s.rst_req & ~s.rst_busy;
            next_s.prdata[BIT_CPU_TO_HOST_IRQ]   = s.cpu_to_host_irq;
            next_s.prdata[BIT_DSPI]   = s.host_to_cpu_irq;
            next_s.prdata[BIT_HALFWORD_ORDER]   = s.halfword_order;
         end else if (paddr == DEV_WADDR_OFS) begin
            next_s.prdata = s.wr_addr;
         end else if (paddr == DEV_RADDR_OFS) begin
            next_s.prdata = s.rd_addr;
         end else begin
            next_s.pslverr = 1'b1;
         end
      end
      cpu_cpu_to_host_irq_set = cpu_wr & (paddr == DEV_CTRL_OFS) & pwdata[BIT_CPU_TO_HOST_IRQ];
      cpu_dsp_clr  = cpu_wr & (paddr == DEV_CTRL_OFS) & pwdata[BIT_DSPI];

      next_s.cpu_to_host_irq   = (s.cpu_to_host_irq & ~host_cpu_to_host_irq_clr) | cpu_cpu_to_host_irq_set;
      next_s.host_to_cpu_irq = (s.host_to_cpu_irq & ~cpu_dsp_clr) | host_dsp_set;

      // FIFO reset starts only between host cycles
      if (s.rst_busy) begin
         if (s.rst_cnt == '0) begin
            next_s.rst_busy = 1'b0;
         end else begin
            next_s.rst_cnt = s.rst_cnt - 1'b1;
         end
      end else if (s.rst_req && !s.half_pend) begin
         next_s.rst_busy = 1'b1;
         next_s.rst_cnt  = RST_LAST;
         next_s.rst_req  = 1'b0;
      end
      if (cpu_wr && paddr == DEV_CTRL_OFS) begin
         // a zero only clears the bit, the pending reset runs on
         next_s.srst = pwdata[BIT_SRST];
         if (pwdata[BIT_SRST]) begin
            next_s.rst_req = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s      <= '0;
         // Host held off until the strap is taken
         s.srst <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign prdata        = s.prdata;
   assign pready        = s.pready;
   assign pslverr       = s.pslverr;
   assign cpu_irq       = s.host_to_cpu_irq;
   assign fifo_flush    = s.rst_busy;
   assign fetch_req     = s.fetch;
   assign mem_wr        = s.mem_wr;
   assign mem_addr      = s.mem_addr;
   assign mem_wdata     = s.mem_wdata;
   assign link.rdy      = s.ack;
   assign link.rdata    = s.rdata;
   assign link.host_irq = s.cpu_to_host_irq;
endmodule : hpc_device
`default_nettype wire

// ===== logic/hpc_pkg.sv
// Shared constants and halfword helpers for the host port control link.
// Assumes both ends run on the same pclk and share this package.
package hpc_pkg;
   // CPU-side register byte offsets on the device end
   localparam logic [31:0] DEV_CTRL_OFS  = 32'h0000_0030;
   localparam logic [31:0] DEV_WADDR_OFS = 32'h0000_0034;
   localparam logic [31:0] DEV_RADDR_OFS = 32'h0000_0038;
   // Host controller register byte offsets
   localparam logic [31:0] HOST_CMD_OFS   = 32'h0000_0000;
   localparam logic [31:0] HOST_WDATA_OFS = 32'h0000_0004;
   localparam logic [31:0] HOST_RDATA_OFS = 32'h0000_0008;
   localparam logic [31:0] HOST_STAT_OFS  = 32'h0000_000c;
   // Control register bit positions
   localparam int BIT_DUAL   = 9;
   localparam int BIT_HWOSTA = 8;
   localparam int BIT_SRST   = 7;
   localparam int BIT_FETCH  = 4;
   localparam int BIT_RDY    = 3;
   localparam int BIT_CPU_TO_HOST_IRQ   = 2;
   localparam int BIT_DSPI   = 1;
   localparam int BIT_HALFWORD_ORDER   = 0;
   localparam logic [31:0] RSVD_MASK = 32'h0000_0060;
   // Host command and status word fields
   localparam int CMD_RW_BIT = 2;
   localparam int STAT_BUSY  = 0;
   localparam int STAT_IRQ   = 1;
   // Link cycle types
   localparam logic [1:0] CNTL_CTRL  = 2'h0;
   localparam logic [1:0] CNTL_WADDR = 2'h1;
   localparam logic [1:0] CNTL_DATA  = 2'h2;
   localparam logic [1:0] CNTL_RADDR = 2'h3;
   // FIFO reset length in pclk cycles
   localparam int          FIFO_RST_CYCLES_DEF = 4;
   localparam int          RST_CNT_W           = 8;
   localparam logic [31:0] ADDR_STEP           = 32'h0000_0001;

   // Halfword sent in a given slot: order 0 sends the upper half first
   function automatic logic [15:0] hpc_half(input logic [31:0] w, input logic halfword_order, input logic second);
      hpc_half = (halfword_order ^ second) ? w[15:0] : w[31:16];
   endfunction : hpc_half

   // Word built from the two halfwords in arrival order
   function automatic logic [31:0] hpc_join(input logic [15:0] first, input logic [15:0] second,
                                            input logic halfword_order);
      hpc_join = halfword_order ? {second, first} : {first, second};
   endfunction : hpc_join
endpackage : hpc_pkg

// ===== logic/hpc_link_if.sv
// Host port link between the external host end and the device end.
// Both ends sit on the same pclk; no clocking block.
`timescale 1ns/1ps
`default_nettype none
interface hpc_link_if;
   logic        req;
   logic        rw;
   logic [1:0]  cntl;
   logic        second;
   logic [15:0] wdata;
   logic        rdy;
   logic [15:0] rdata;
   logic        host_irq;

   modport device (input req, input rw, input cntl, input second, input wdata,
                   output rdy, output rdata, output host_irq);
   modport host   (output req, output rw, output cntl, output second, output wdata,
                   input rdy, input rdata, input host_irq);
endinterface : hpc_link_if
`default_nettype wire

// ===== logic/hpc_host.sv
// Host end: turns APB commands into two-halfword link cycles.
// Assumes the device end answers each halfword with a one-cycle rdy pulse.
`timescale 1ns/1ps
`default_nettype none
module hpc_host (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   hpc_link_if.host         link,
   output logic             host_irq
);
   import hpc_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_HALF1 = 3'b010,
      ST_HALF2 = 3'b100
   } hpc_host_state_e;

   typedef struct packed {
      hpc_host_state_e st;
      logic            halfword_order;
      logic [31:0]     wword;
      logic [31:0]     rword;
      logic            req;
      logic            rw;
      logic [1:0]      cntl;
      logic            second;
      logic [15:0]     wdata;
      logic            pready;
      logic [31:0]     prdata;
      logic            pslverr;
   } hpc_host_s;

   hpc_host_s s;
   hpc_host_s next_s;
   logic      apb_wr;
   logic [31:0] out_word;

   always_comb begin
      next_s = s;
      apb_wr = psel & penable & pwrite & s.pready;
      // reserved bits sent as zero in control cycles only
      out_word = (s.cntl == CNTL_CTRL) ? (s.wword & ~RSVD_MASK) : s.wword;

      unique case (s.st)
         ST_IDLE: begin
            if (apb_wr && paddr == HOST_CMD_OFS) begin
               next_s.st     = ST_HALF1;
               next_s.req    = 1'b1;
               next_s.rw     = pwdata[CMD_RW_BIT];
               next_s.cntl   = pwdata[1:0];
               next_s.second = 1'b0;
               next_s.wdata  = hpc_half((pwdata[1:0] == CNTL_CTRL) ? (s.wword & ~RSVD_MASK) : s.wword,
                                        s.halfword_order, 1'b0);
            end
         end
         // wait as long as the device holds rdy low
         ST_HALF1: begin
            if (link.rdy) begin
               next_s.st     = ST_HALF2;
               next_s.second = 1'b1;
               next_s.wdata  = hpc_half(out_word, s.halfword_order, 1'b1);
               next_s.rword  = {16'h0000, link.rdata};
            end
         end
         ST_HALF2: begin
            if (link.rdy) begin
               next_s.st    = ST_IDLE;
               next_s.req   = 1'b0;
               next_s.rword = hpc_join(s.rword[15:0], link.rdata, s.halfword_order);
               // order tracks what the host last programmed
               if (!s.rw && s.cntl == CNTL_CTRL) begin
                  next_s.halfword_order = s.wword[BIT_HALFWORD_ORDER];
               end
            end
         end
      endcase

      if (apb_wr && paddr == HOST_WDATA_OFS) begin
         next_s.wword = pwdata;
      end

      next_s.pready  = psel & ~penable & ~s.pready;
      next_s.prdata  = 32'h0000_0000;
      next_s.pslverr = 1'b0;
      if (psel && !penable) begin
         if (paddr == HOST_WDATA_OFS) begin
            next_s.prdata = s.wword;
         end else if (paddr == HOST_RDATA_OFS) begin
            next_s.prdata = s.rword;
         end else if (paddr == HOST_STAT_OFS) begin
            next_s.prdata[STAT_BUSY] = (s.st != ST_IDLE);
            next_s.prdata[STAT_IRQ]  = link.host_irq;
         end else if (paddr != HOST_CMD_OFS) begin
            next_s.pslverr = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s    <= '0;
         s.st <= ST_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign prdata      = s.prdata;
   assign pready      = s.pready;
   assign pslverr     = s.pslverr;
   assign host_irq    = link.host_irq;
   assign link.req    = s.req;
   assign link.rw     = s.rw;
   assign link.cntl   = s.cntl;
   assign link.second = s.second;
   assign link.wdata  = s.wdata;
endmodule : hpc_host
`default_nettype wire

// ===== tb/hpc_link_checker.sv
// Checker for the host port link between host end and device end.
// Assumes all link signals are sampled on pclk, reset by presetn.
`timescale 1ns/1ps
`default_nettype none
module hpc_link_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        req,
   input wire logic        rw,
   input wire logic [1:0]  cntl,
   input wire logic        second,
   input wire logic [15:0] wdata,
   input wire logic        rdy,
   input wire logic [15:0] rdata,
   input wire logic        host_irq
);
   import hpc_pkg::*;
   logic [15:0] ctrl_first;
   logic        ctrl_wr;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   assign ctrl_wr = rdy && second && !rw && (cntl == CNTL_CTRL);

   // First half of a control read, kept to compare with the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_first <= '0;
      end else if (rdy && !second && rw && cntl == CNTL_CTRL) begin
         ctrl_first <= rdata;
      end
   end

   property p_rdy_pulse;
      rdy |=> !rdy;
   endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("rdy longer than one cycle");

   property p_rdy_req;
      $rose(req) |-> !rdy;
   endproperty
   a_rdy_req: assert property (p_rdy_req) else $error("rdy in the cycle a request opens");

   property p_hold;
      req && !rdy |=> req && $stable(cntl) && $stable(rw) && $stable(second) && $stable(wdata);
   endproperty
   a_hold: assert property (p_hold) else $error("link request changed before rdy");

   property p_second;
      rdy && req && !second |=> req && second && $stable(cntl) && $stable(rw);
   endproperty
   a_second: assert property (p_second) else $error("second halfword did not follow");

   property p_after;
      rdy && second |=> !req || !second;
   endproperty
   a_after: assert property (p_after) else $error("third halfword in one cycle");

   property p_rdata;
      !$stable(rdata) |-> rdy;
   endproperty
   a_rdata: assert property (p_rdata) else $error("rdata changed without rdy");

   property p_irq_clear;
      $fell(host_irq) |-> ctrl_wr || $past(ctrl_wr) || $past(ctrl_wr, 2);
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("host irq cleared without host write");

   property p_ctrl_halves;
      rdy && rw && second && cntl == CNTL_CTRL |-> rdata == ctrl_first;
   endproperty
   a_ctrl_halves: assert property (p_ctrl_halves) else $error("control halves differ");
endmodule : hpc_link_checker
`default_nettype wire

// ===== tb/host_port_control_reg_test.sv
// Testbench: host end and device end joined by the link, both driven over APB.
// Assumes one APB master per end and a short FIFO reset set by parameter.
`timescale 1ns/1ps
`default_nettype none
module host_port_control_reg_test;
   import hpc_pkg::*;
   localparam int RST_LEN = 8;
   logic        pclk, presetn, boot, err, cpu_irq, host_irq, fifo_flush, fetch_req, mem_wr;
   logic [1:0]  psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr [2];
   logic [31:0] pwdata [2];
   logic [31:0] prdata [2];
   logic [31:0] mem_addr, mem_wdata, mem_rdata, rd, mw_addr, mw_data;
   logic [15:0] hw [2];
   logic [15:0] hr [2];
   int          mismatches, n_tests, flush_len, fetches;
   hpc_link_if  lk ();

   hpc_device #(.FIFO_RST_CYCLES(RST_LEN)) i_hpc_device (.pclk(pclk), .presetn(presetn),
      .psel(psel[0]), .penable(penable[0]), .pwrite(pwrite[0]), .paddr(paddr[0]), .pwdata(pwdata[0]),
      .prdata(prdata[0]), .pready(pready[0]), .pslverr(pslverr[0]), .boot_from_port(boot), .link(lk),
      .cpu_irq(cpu_irq), .fifo_flush(fifo_flush), .fetch_req(fetch_req), .mem_wr(mem_wr),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   hpc_host i_hpc_host (.pclk(pclk), .presetn(presetn), .psel(psel[1]), .penable(penable[1]),
      .pwrite(pwrite[1]), .paddr(paddr[1]), .pwdata(pwdata[1]), .prdata(prdata[1]), .pready(pready[1]),
      .pslverr(pslverr[1]), .link(lk), .host_irq(host_irq));
   hpc_link_checker i_hpc_link_checker (.pclk(pclk), .presetn(presetn), .req(lk.req), .rw(lk.rw),
      .cntl(lk.cntl), .second(lk.second), .wdata(lk.wdata), .rdy(lk.rdy), .rdata(lk.rdata),
      .host_irq(lk.host_irq));

   // Memory answers with the inverse of its address
   assign mem_rdata = ~mem_addr;

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (lk.rdy === 1'b1) begin
         hw[lk.second] = lk.wdata;
         hr[lk.second] = lk.rdata;
      end
      if (mem_wr === 1'b1) begin
         mw_addr = mem_addr;
         mw_data = mem_wdata;
      end
      if (fifo_flush === 1'b1) flush_len++;
      if (fetch_req === 1'b1) fetches++;
   end

   task automatic stop_test();
      if (mismatches == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Port 0 is the device CPU side, port 1 the host end
   task automatic apb(input int p, input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel[p]   <= 1'b1;
      pwrite[p] <= wr;
      paddr[p]  <= a;
      pwdata[p] <= d;
      @(posedge pclk);
      penable[p] <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready[p] !== 1'b1 && n < 20);
      if (pready[p] !== 1'b1) begin
         mismatches++;
         stop_test();
      end
      rd  = prdata[p];
      err = pslverr[p];
      psel[p]    <= 1'b0;
      penable[p] <= 1'b0;
   endtask : apb

   task automatic cmd(input logic [1:0] c, input logic r, input logic [31:0] w);
      apb(1, 1'b1, HOST_WDATA_OFS, w);
      apb(1, 1'b1, HOST_CMD_OFS, {29'h0, r, c});
   endtask : cmd

   task automatic link(input logic [1:0] c, input logic r, input logic [31:0] w);
      int n;
      cmd(c, r, w);
      n = 0;
      do begin
         apb(1, 1'b0, HOST_STAT_OFS, 32'h0);
         n++;
      end while (rd[STAT_BUSY] !== 1'b0 && n < 40);
      if (rd[STAT_BUSY] !== 1'b0) begin
         mismatches++;
         stop_test();
      end
      if (r) apb(1, 1'b0, HOST_RDATA_OFS, 32'h0);
   endtask : link

   task automatic s_boot();
      apb(0, 1'b0, DEV_CTRL_OFS, 32'h0);
      check("boot ctrl", rd, 32'h0000_0080);
      apb(0, 1'b0, 32'h0000_003c, 32'h0);
      check("unmapped", {31'h0, err}, 32'h1);
      cmd(CNTL_CTRL, 1'b0, 32'h0000_0002);
      repeat (12) @(posedge pclk);
      apb(1, 1'b0, HOST_STAT_OFS, 32'h0);
      check("held busy", {31'h0, rd[STAT_BUSY]}, 32'h1);
      apb(0, 1'b1, DEV_CTRL_OFS, 32'h0);
      link(CNTL_CTRL, 1'b1, 32'h0);
      check("cpu irq set", {31'h0, cpu_irq}, 32'h1);
      apb(0, 1'b1, DEV_CTRL_OFS, 32'h0);
      // The write lands on the edge the task returns at, so look one edge later
      @(posedge pclk);
      check("cpu irq kept", {31'h0, cpu_irq}, 32'h1);
      apb(0, 1'b1, DEV_CTRL_OFS, 32'h2);
      @(posedge pclk);
      check("cpu irq clr", {31'h0, cpu_irq}, 32'h0);
   endtask : s_boot

   task automatic s_irq();
      apb(0, 1'b1, DEV_CTRL_OFS, 32'h4);
      apb(1, 1'b0, HOST_STAT_OFS, 32'h0);
      check("host irq set", {31'h0, rd[STAT_IRQ]}, 32'h1);
      link(CNTL_CTRL, 1'b0, 32'h0);
      check("host irq kept", {31'h0, host_irq}, 32'h1);
      link(CNTL_CTRL, 1'b0, 32'h4);
      check("host irq clr", {31'h0, host_irq}, 32'h0);
   endtask : s_irq

   task automatic s_single();
      link(CNTL_WADDR, 1'b0, 32'h1234_5678);
      check("wire half 0", {16'h0, hw[0]}, 32'h1234);
      check("wire half 1", {16'h0, hw[1]}, 32'h5678);
      apb(0, 1'b0, DEV_WADDR_OFS, 32'h0);
      check("waddr", rd, 32'h1234_5678);
      apb(0, 1'b0, DEV_RADDR_OFS, 32'h0);
      check("raddr", rd, 32'h1234_5678);
      link(CNTL_WADDR, 1'b1, 32'h0);
      check("addr read", rd, 32'h1234_5678);
      link(CNTL_DATA, 1'b0, 32'hcafe_f00d);
      check("mem addr", mw_addr, 32'h1234_5678);
      check("mem data", mw_data, 32'hcafe_f00d);
      apb(0, 1'b0, DEV_RADDR_OFS, 32'h0);
      check("raddr inc", rd, 32'h1234_5679);
      apb(0, 1'b0, DEV_WADDR_OFS, 32'h0);
      check("waddr inc", rd, 32'h1234_5679);
      link(CNTL_DATA, 1'b1, 32'h0);
      check("data read", rd, 32'hedcb_a986);
      check("read half 0", {16'h0, hr[0]}, 32'hedcb);
   endtask : s_single

   task automatic s_order();
      link(CNTL_CTRL, 1'b0, 32'h0000_0001);
      apb(0, 1'b0, DEV_CTRL_OFS, 32'h0);
      check("order mirror", rd, 32'h0000_0101);
      link(CNTL_CTRL, 1'b1, 32'h0);
      check("host ctrl", rd & 32'hff77_ff77, 32'h0101_0101);
      check("host ready", rd & 32'h8, 32'h8);
      check("host srst", rd & 32'h80, 32'h0);
      link(CNTL_WADDR, 1'b0, 32'h1234_5678);
      check("swap half 0", {16'h0, hw[0]}, 32'h5678);
      link(CNTL_WADDR, 1'b1, 32'h0);
      check("swap read", {16'h0, hr[0]}, 32'h5678);
      check("swap word", rd, 32'h1234_5678);
   endtask : s_order

   task automatic s_dual();
      fetches = 0;
      link(CNTL_CTRL, 1'b0, 32'h0000_0271);
      apb(0, 1'b0, DEV_CTRL_OFS, 32'h0);
      check("dual ctrl", rd, 32'h0000_0301);
      check("fetch", fetches, 32'h1);
      link(CNTL_WADDR, 1'b0, 32'h0000_1000);
      link(CNTL_RADDR, 1'b0, 32'h0000_2000);
      apb(0, 1'b0, DEV_WADDR_OFS, 32'h0);
      check("dual waddr", rd, 32'h0000_1000);
      apb(0, 1'b0, DEV_RADDR_OFS, 32'h0);
      check("dual raddr", rd, 32'h0000_2000);
   endtask : s_dual

   task automatic s_flush();
      int n;
      flush_len = 0;
      apb(0, 1'b1, DEV_CTRL_OFS, 32'h80);
      apb(0, 1'b0, DEV_CTRL_OFS, 32'h0);
      check("srst pending", rd & 32'h80, 32'h0);
      apb(0, 1'b1, DEV_CTRL_OFS, 32'h0);
      for (n = 0; n < 40 && fifo_flush !== 1'b0; n++) @(posedge pclk);
      if (fifo_flush !== 1'b0) begin
         mismatches++;
         stop_test();
      end
      check("flush len", flush_len, RST_LEN);
      link(CNTL_WADDR, 1'b1, 32'h0);
      check("resume", rd, 32'h0000_1000);
   endtask : s_flush

   // Second reset in mid-run with the port boot strap set
   task automatic s_strap();
      @(posedge pclk);
      boot    <= 1'b1;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 1'b0, DEV_CTRL_OFS, 32'h0);
      check("strap ctrl", rd, 32'h0000_0000);
      link(CNTL_WADDR, 1'b1, 32'h0);
      check("strap addr", rd, 32'h0000_0000);
      apb(1, 1'b0, 32'h0000_0010, 32'h0);
      check("host unmapped", {31'h0, err}, 32'h1);
   endtask : s_strap

   initial begin
      psel       = '0;
      penable    = '0;
      pwrite     = '0;
      paddr      = '{32'h0, 32'h0};
      pwdata     = '{32'h0, 32'h0};
      boot       = 1'b0;
      presetn    = 1'b0;
      mismatches = 0;
      n_tests    = 0;
      flush_len  = 0;
      fetches    = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      s_boot();
      s_irq();
      s_single();
      s_order();
      s_dual();
      s_flush();
      s_strap();
      stop_test();
   end
endmodule : host_port_control_reg_test
`default_nettype wire
